// >>> rtl/scrl_core.sv
// scrl_core: serial load, register commits and counters of the synthesizer
//
// Operation
// - configuration commit stores byte only
// - divider commit stores divider bytes
// - divider commit copies first reference buffer
// - reference commit applies output divider bits
// - reference commit fills first buffer only
// - reference counter switches at cycle end
// - feedback divides by main*64 plus swallow
// - reference counter yields comparison frequency
// - open-drain output follows configuration bit
// - reference access is sixteen clocks
// - power-on output ratio is eight
module scrl_core (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // serial port pins
  input  wire logic serial_clock,
  input  wire logic serial_data,
  input  wire logic serial_latch_strobe,
  // frequency inputs
  input  wire logic reference_input,
  input  wire logic vco_input,
  // frequency outputs
  output logic      reference_output,
  output logic      comparison_frequency,
  output logic      feedback_frequency,
  // general outputs
  output logic      gen_out_a,
  output logic      gen_out_b_o,
  output logic      gen_out_b_oe_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [scrl_pkg::PIN_N-1:0] s1_q, s2_q, s3_q;  // three-stage chains
  logic [scrl_pkg::PIN_N-1:0] filt_q, filt_d;    // agreed pin levels
  logic [scrl_pkg::PIN_N-1:0] rise_q, rise_d;    // one-cycle rise marks

  // a level counts only once stages two and three agree
  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
    rise_d = filt_d & ~filt_q;
  end

  // chains and filtered levels; pins sit low after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
      rise_q <= '0;
    end else begin
      s1_q   <= {vco_input, reference_input, serial_latch_strobe,
                 serial_data, serial_clock};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      rise_q <= rise_d;
    end
  end

  logic sclk_rise;  // serial clock rising edge
  logic stb_rise;   // strobe rising edge commits
  logic din_lvl;    // data level at clock edge
  logic stb_lvl;    // strobe level
  logic ref_rise;   // reference input edge
  logic vco_rise;   // oscillator input edge
  assign sclk_rise = rise_q[scrl_pkg::PIN_SCLK];
  assign stb_rise  = rise_q[scrl_pkg::PIN_STB];
  assign din_lvl   = filt_q[scrl_pkg::PIN_DIN];
  assign stb_lvl   = filt_q[scrl_pkg::PIN_STB];
  assign ref_rise  = rise_q[scrl_pkg::PIN_REF];
  assign vco_rise  = rise_q[scrl_pkg::PIN_VCO];

  // ----------------------------------------------------------------
  // serial shift and register commits
  // ----------------------------------------------------------------
  logic [scrl_pkg::SHIFT_W-1:0] sh_q, sh_d;       // shift register
  logic [4:0]                   cnt_q, cnt_d;     // clocks in frame
  logic [scrl_pkg::CFG_W-1:0]   cfg_q, cfg_d;     // configuration
  logic [scrl_pkg::SHIFT_W-1:0] div_q, div_d;     // main/swallow
  logic [scrl_pkg::RB_W-1:0]    rb1_q, rb1_d;     // first buffer
  logic [scrl_pkg::RB_W-1:0]    rb2_q, rb2_d;     // second buffer
  logic [scrl_pkg::RSEL_W-1:0]  rsel_q, rsel_d;   // output divider code
  logic                         dout_q, dout_d;   // cascade data out

  // frame length picks the register; no address bits in the stream
  always_comb begin
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    cfg_d  = cfg_q;
    div_d  = div_q;
    rb1_d  = rb1_q;
    rb2_d  = rb2_q;
    rsel_d = rsel_q;
    dout_d = dout_q;
    if (stb_rise) begin
      // strobe ends the frame, the counter restarts for the next one
      cnt_d = scrl_pkg::NO_BITS;
      unique case (cnt_q)
        scrl_pkg::CFG_BITS: begin
          cfg_d = sh_q[scrl_pkg::CFG_W-1:0];
        end
        scrl_pkg::DIV_BITS: begin
          div_d = sh_q;
          rb2_d = rb1_q;
        end
        scrl_pkg::REF_BITS: begin
          rsel_d = sh_q[scrl_pkg::RSEL_LSB +: scrl_pkg::RSEL_W];
          rb1_d  = sh_q[scrl_pkg::RB_LSB +: scrl_pkg::RB_W];
        end
        scrl_pkg::NO_BITS: begin
          // bare strobe with clock held low moves the first buffer on
          rb2_d = rb1_q;
        end
        default: begin
          // any other length is dropped, nothing changes
        end
      endcase
    end else if (sclk_rise && !stb_lvl) begin
      // msb first; the bit leaving the top feeds the next device
      dout_d = sh_q[scrl_pkg::SHIFT_W-1];
      sh_d   = {sh_q[scrl_pkg::SHIFT_W-2:0], din_lvl};
      if (cnt_q != scrl_pkg::CNT_MAX) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  // register storage; power-on state sets output ratio eight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_q   <= '0;
      cnt_q  <= scrl_pkg::NO_BITS;
      cfg_q  <= scrl_pkg::CFG_RST;
      div_q  <= scrl_pkg::DIV_RST;
      rb1_q  <= scrl_pkg::RB_RST;
      rb2_q  <= scrl_pkg::RB_RST;
      rsel_q <= scrl_pkg::RSEL_RST;
      dout_q <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      cfg_q  <= cfg_d;
      div_q  <= div_d;
      rb1_q  <= rb1_d;
      rb2_q  <= rb2_d;
      rsel_q <= rsel_d;
      dout_q <= dout_d;
    end
  end

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  logic [scrl_pkg::FB_W-1:0] fb_ratio;            // total feedback ratio
  logic [scrl_pkg::FB_W-1:0] fb_q, fb_d;          // feedback counter
  logic                      fbo_q, fbo_d;        // feedback pulse
  logic [scrl_pkg::RB_W-1:0] rc_q, rc_d;          // reference counter
  logic [scrl_pkg::RB_W-1:0] rr_q, rr_d;          // ratio in use
  logic                      cmp_q, cmp_d;        // comparison pulse
  logic [scrl_pkg::OD_W-1:0] od_q, od_d;          // output divider
  logic                      rout_q, rout_d;      // reference output

  // main times 64 is a shift by the swallow width
  assign fb_ratio = {div_q[scrl_pkg::MAIN_LSB +: scrl_pkg::MAIN_W],
                     {scrl_pkg::SWL_W{1'b0}}}
                  + {{scrl_pkg::MAIN_W{1'b0}}, div_q[scrl_pkg::SWL_W-1:0]};

  // one pulse per full count on each input; ratios below two pass edges
  always_comb begin
    fb_d   = fb_q;
    fbo_d  = 1'b0;
    rc_d   = rc_q;
    rr_d   = rr_q;
    cmp_d  = 1'b0;
    od_d   = od_q;
    rout_d = rout_q;
    if (vco_rise) begin
      if (fb_q + 18'h00001 >= fb_ratio) begin
        fb_d  = '0;
        fbo_d = 1'b1;
      end else begin
        fb_d = fb_q + 18'h00001;
      end
    end
    if (ref_rise) begin
      od_d = od_q + 4'h1;
      if (rc_q + 13'h0001 >= rr_q) begin
        rc_d  = '0;
        cmp_d = 1'b1;
        // new ratio taken only at the end of the running count
        rr_d  = rb2_q;
      end else begin
        rc_d = rc_q + 13'h0001;
      end
    end
    // output divider: off, pass, or a tap of the four-stage chain
    if (rsel_q == scrl_pkg::RSEL_OFF) begin
      rout_d = 1'b0;
    end else if (rsel_q == scrl_pkg::RSEL_PASS) begin
      rout_d = filt_q[scrl_pkg::PIN_REF];
    end else if (rsel_q - scrl_pkg::RSEL_BASE >= 3'(scrl_pkg::OD_W)) begin
      rout_d = od_d[scrl_pkg::OD_W-1];
    end else begin
      rout_d = od_d[2'(rsel_q - scrl_pkg::RSEL_BASE)];
    end
  end

  // counter state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fb_q   <= '0;
      fbo_q  <= 1'b0;
      rc_q   <= '0;
      rr_q   <= scrl_pkg::RB_RST;
      cmp_q  <= 1'b0;
      od_q   <= '0;
      rout_q <= 1'b0;
    end else begin
      fb_q   <= fb_d;
      fbo_q  <= fbo_d;
      rc_q   <= rc_d;
      rr_q   <= rr_d;
      cmp_q  <= cmp_d;
      od_q   <= od_d;
      rout_q <= rout_d;
    end
  end

  // ----------------------------------------------------------------
  // general outputs
  // ----------------------------------------------------------------
  logic outa_q, outa_d;    // push-pull output
  logic outb_q, outb_d;    // open-drain enable, low drives the pin

  // output b can pull the base of a standby switch transistor
  always_comb begin
    outa_d = cfg_q[scrl_pkg::CFG_OUTA_DOUT] ? dout_d
                                            : cfg_q[scrl_pkg::CFG_OUTA_LVL];
    outb_d = cfg_q[scrl_pkg::CFG_OUTB_LVL];
  end

  // output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      outa_q <= 1'b0;
      outb_q <= 1'b1;
    end else begin
      outa_q <= outa_d;
      outb_q <= outb_d;
    end
  end

  assign gen_out_a            = outa_q;
  assign gen_out_b_oe_n       = outb_q;
  assign gen_out_b_o          = 1'b0;
  assign reference_output     = rout_q;
  assign comparison_frequency = cmp_q;
  assign feedback_frequency   = fbo_q;

endmodule

// >>> shared/scrl_pkg.sv
// scrl_pkg: constants for the synthesizer serial register-load block
package scrl_pkg;

  // ----------------------------------------------------------------
  // frame lengths in serial clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] CFG_BITS   = 5'h08;   // configuration access
  localparam logic [4:0] REF_BITS   = 5'h10;   // reference access
  localparam logic [4:0] DIV_BITS   = 5'h18;   // divider access
  localparam logic [4:0] NO_BITS    = 5'h00;   // strobe without clocks
  localparam logic [4:0] CNT_MAX    = 5'h1F;   // bit counter saturates here
  localparam int         SHIFT_W    = 24;      // shift register width

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int CFG_W       = 8;    // configuration register width
  localparam int RB_W        = 13;   // reference counter buffers
  localparam int RB_LSB      = 0;    // reference buffer field low bit
  localparam int RSEL_LSB    = 13;   // output divider select low bit
  localparam int RSEL_W      = 3;    // output divider select width
  localparam int SWL_W       = 6;    // swallow counter field
  localparam int MAIN_LSB    = 6;    // main counter field low bit
  localparam int MAIN_W      = 12;   // main counter field width
  localparam int FB_W        = 18;   // total feedback ratio width
  localparam int OD_W        = 4;    // four-stage output divider

  // configuration bits steering the general outputs
  localparam int CFG_OUTA_DOUT = 0;  // output a carries shifted data
  localparam int CFG_OUTA_LVL  = 1;  // output a level when not data
  localparam int CFG_OUTB_LVL  = 2;  // output b: 0 pulls low, 1 releases

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0]  CFG_RST  = 8'h04;     // output b released
  localparam logic [SHIFT_W-1:0] DIV_RST = 24'h000000;
  localparam logic [RB_W-1:0]   RB_RST   = 13'h0001;  // divide by one
  localparam logic [RSEL_W-1:0] RSEL_RST = 3'h4;      // output ratio eight

  // output divider select codes
  localparam logic [RSEL_W-1:0] RSEL_OFF  = 3'h0;  // output held low
  localparam logic [RSEL_W-1:0] RSEL_PASS = 3'h1;  // input passed through
  localparam logic [RSEL_W-1:0] RSEL_BASE = 3'h2;  // first divided code

  // synchronised pin vector positions
  localparam int PIN_N    = 5;
  localparam int PIN_SCLK = 0;
  localparam int PIN_DIN  = 1;
  localparam int PIN_STB  = 2;
  localparam int PIN_REF  = 3;
  localparam int PIN_VCO  = 4;

endpackage

// >>> dv/scrl_core_assertions.sv
// scrl_core_assertions: port-level checks of the serial load block
module scrl_core_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic serial_latch_strobe,
  input wire logic reference_input,
  input wire logic vco_input,
  // outputs
  input wire logic reference_output,
  input wire logic comparison_frequency,
  input wire logic feedback_frequency,
  input wire logic gen_out_a,
  input wire logic gen_out_b_o,
  input wire logic gen_out_b_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // clocks since each pin rose: ref, vco, serial clock, strobe
  // --------
  logic [3:0] pin_q, pin_d;      // last sampled pin levels
  logic [4:0] age_q [4];         // saturates so an old edge never looks recent
  logic [4:0] age_d [4];         // next ages
  // raw pins are sampled like the design's first sync stage
  always_comb begin
    pin_d = {serial_latch_strobe, serial_clock, vco_input, reference_input};
    for (int i = 0; i < 4; i++) begin
      if (pin_d[i] && !pin_q[i]) age_d[i] = 5'h00;
      else if (age_q[i] != 5'h1F) age_d[i] = age_q[i] + 5'h01;
      else age_d[i] = 5'h1F;
    end
  end
  // register the ages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 4'h0;
      age_q <= '{default: 5'h1F};
    end else begin
      pin_q <= pin_d;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // --------
  // assertions
  // --------
  sequence cmp_single;
    comparison_frequency ##1 !comparison_frequency [*3];
  endsequence
  sequence fb_single;
    feedback_frequency ##1 !feedback_frequency [*3];
  endsequence
  open_drain_low_a: assert property (gen_out_b_o == 1'b0)
    else $error("open-drain value not low");
  drain_cause_a: assert property (!$stable(gen_out_b_oe_n) |-> age_q[3] <= 5'h0C)
    else $error("drain enable moved without a commit");
  cascade_cause_a: assert property (!$stable(gen_out_a) |->
    age_q[2] <= 5'h0C || age_q[3] <= 5'h0C)
    else $error("output a moved without shift or commit");
  cmp_pulse_a: assert property (comparison_frequency |-> cmp_single)
    else $error("comparison pulse not single");
  fb_pulse_a: assert property (feedback_frequency |-> fb_single)
    else $error("feedback pulse not single");
  cmp_after_ref_a: assert property (comparison_frequency |-> age_q[0] <= 5'h0C)
    else $error("comparison pulse without reference edge");
  fb_after_vco_a: assert property (feedback_frequency |-> age_q[1] <= 5'h0C)
    else $error("feedback pulse without oscillator edge");
  reference_output_cause_a: assert property ($rose(reference_output) |->
    age_q[0] <= 5'h0C || age_q[3] <= 5'h0C)
    else $error("reference output rose without cause");
endmodule

// >>> dv/scrl_host.sv
// scrl_host: host serial port model driving the load pins
module scrl_host (
  // clock
  input  wire logic clk,
  // pins toward the device
  output logic      serial_clock,
  output logic      serial_data,
  output logic      serial_latch_strobe,
  // cascade data coming back
  input  wire logic gen_out_a
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] dout_q;  // cascade bit pushed out by each rise, oldest first
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    serial_latch_strobe = 1'b0;
    dout_q = 32'h0;
  end
  // shift n bits msb first, one per clock pulse, then strobe
  task automatic send(input logic [31:0] val, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= val[i];
      repeat (4) @(posedge clk);
      // out a settles some five clocks after a rise, so the bit that the
      // previous rise pushed out is taken just before this rise
      if (i != n - 1) begin
        dout_q <= {dout_q[30:0], gen_out_a};
      end
      serial_clock <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clk);
    if (n > 0) begin
      dout_q <= {dout_q[30:0], gen_out_a};  // bit pushed by the last rise
    end
    serial_latch_strobe <= 1'b1;  // clock stays low across the pulse
    repeat (8) @(posedge clk);
    serial_latch_strobe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// >>> dv/tb_scrl_core.sv
// tb_scrl_core: self-checking bench for the serial register-load block
module tb_scrl_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0;              // 40 MHz
  logic       nrst = 1'b0;             // held low for three clocks
  logic [2:0] phase_q = 3'h0;          // eight-clock period of both inputs
  logic       reference_input = 1'b0;  // reference pin
  logic       vco_input = 1'b0;        // oscillator pin
  logic       serial_clock, serial_data, serial_latch_strobe;
  logic       reference_output, comparison_frequency, feedback_frequency;
  logic       gen_out_a, gen_out_b_o, gen_out_b_oe_n;
  logic [2:0] outs;                    // measured outputs
  int         bad_count = 0;
  int         samples_checked = 0;
  assign outs = {reference_output, comparison_frequency, feedback_frequency};
  always #12.5 clk = ~clk;
  // free-running frequency inputs
  always @(posedge clk) begin
    phase_q <= phase_q + 3'h1;
    reference_input <= phase_q[2];
    vco_input <= phase_q[2];
  end
  scrl_core i_scrl_core (.clk(clk), .nrst(nrst), .serial_clock(serial_clock),
    .serial_data(serial_data), .serial_latch_strobe(serial_latch_strobe),
    .reference_input(reference_input), .vco_input(vco_input),
    .reference_output(reference_output), .comparison_frequency(comparison_frequency),
    .feedback_frequency(feedback_frequency), .gen_out_a(gen_out_a),
    .gen_out_b_o(gen_out_b_o), .gen_out_b_oe_n(gen_out_b_oe_n));
  scrl_host i_scrl_host (.clk(clk), .serial_clock(serial_clock), .serial_data(serial_data),
    .serial_latch_strobe(serial_latch_strobe), .gen_out_a(gen_out_a));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // clocks between two rises of output k (2 reference_output, 1 cmp, 0 fb)
  task automatic meas(input string what, input int k, input logic [15:0] exp);
    logic p;
    int t;
    int t0;
    int per;
    p = 1'b1;
    t = 0;
    t0 = 0;
    per = 0;
    for (int n = 0; n < 4000 && t < 2; n++) begin
      @(posedge clk);
      if (outs[k] === 1'b1 && p !== 1'b1) begin
        t++;
        per = n - t0;
        t0 = n;
      end
      p = outs[k];
    end
    chk(what, 16'(per), exp);
  endtask
  // power-on ratios
  task automatic t_power_on();
    meas("reference_output", 2, 16'h0040);
    meas("cmp", 1, 16'h0008);
    meas("fb", 0, 16'h0008);
    chk("drain", {15'h0, gen_out_b_oe_n}, 16'h0001);
  endtask
  // configuration byte drives the outputs only
  task automatic t_config();
    i_scrl_host.send(32'h0000_0002, 8);
    chk("out a", {15'h0, gen_out_a}, 16'h0001);
    chk("drain", {15'h0, gen_out_b_oe_n}, 16'h0000);
    meas("reference_output", 2, 16'h0040);
  endtask
  // reference frame: output ratio at once, counter waits; short frame dropped
  task automatic t_reference();
    i_scrl_host.send({16'h0, 3'h2, 13'h0005}, 16);
    meas("reference_output", 2, 16'h0010);
    meas("cmp", 1, 16'h0008);
    chk("out a", {15'h0, gen_out_a}, 16'h0001);
    i_scrl_host.send({17'h0, 3'h5, 12'h007}, 15);
    meas("reference_output", 2, 16'h0010);
  endtask
  // divider frame: feedback ratio and buffered reference ratio together
  task automatic t_divider();
    i_scrl_host.send({8'h0, 6'h00, 12'h001, 6'h02}, 24);
    meas("fb", 0, 16'h0210);
    meas("cmp", 1, 16'h0028);
    chk("out a", {15'h0, gen_out_a}, 16'h0001);
  endtask
  // clock-free strobe moves the first buffer across
  task automatic t_transfer();
    i_scrl_host.send({16'h0, 3'h2, 13'h0003}, 16);
    meas("cmp", 1, 16'h0028);
    i_scrl_host.send(32'h0, 0);
    meas("cmp", 1, 16'h0018);
  endtask
  // data out passes bits on; overlong frame is dropped
  task automatic t_cascade();
    i_scrl_host.send(32'h0000_0001, 8);
    i_scrl_host.send(32'hA500_0000, 32);
    chk("cascade", {8'h0, i_scrl_host.dout_q[7:0]}, 16'h00A5);
    meas("fb", 0, 16'h0210);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_power_on();
    t_config();
    t_reference();
    t_divider();
    t_transfer();
    t_cascade();
    test_done();
  end
  // watchdog well past the expected run of some 4000 clocks
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
bind scrl_core scrl_core_assertions i_scrl_core_assertions (.clk(clk), .nrst(nrst),
  .serial_clock(serial_clock), .serial_data(serial_data),
  .serial_latch_strobe(serial_latch_strobe), .reference_input(reference_input),
  .vco_input(vco_input), .reference_output(reference_output),
  .comparison_frequency(comparison_frequency), .feedback_frequency(feedback_frequency),
  .gen_out_a(gen_out_a), .gen_out_b_o(gen_out_b_o), .gen_out_b_oe_n(gen_out_b_oe_n));
